//--- fwlie_regs.vh
// Register offsets, field positions and reset values for the event block
`ifndef FWLIE_REGS_VH
`define FWLIE_REGS_VH
`define FWLIE_EVT_SET     8'h80
`define FWLIE_EVT_CLR     8'h84
`define FWLIE_MSK_SET     8'h88
`define FWLIE_MSK_CLR     8'h8c
`define FWLIE_RAW         8'h90
`define FWLIE_GATE_BIT    31
`define FWLIE_LOST_BIT    22
`define FWLIE_S64_BIT     21
`define FWLIE_CYC_BIT     20
`define FWLIE_PHY_BIT     19
`define FWLIE_RAF_BIT     18
`define FWLIE_BR_BIT      17
`define FWLIE_ID_BIT      16
`define FWLIE_ID2_BIT     15
`define FWLIE_LOCK_BIT    9
`define FWLIE_PW_BIT      8
`define FWLIE_IRX_BIT     7
`define FWLIE_ITX_BIT     6
`define FWLIE_RSPPKT_BIT  5
`define FWLIE_REQPKT_BIT  4
`define FWLIE_RXRSP_BIT   3
`define FWLIE_RXREQ_BIT   2
`define FWLIE_TXRSP_BIT   1
`define FWLIE_TXREQ_BIT   0
`define FWLIE_LATCH_MASK  32'h007f833f
`define FWLIE_MASK_MASK   32'h807f83ff
`define FWLIE_EVT_RESET   32'h00000000
`define FWLIE_MSK_RESET   32'h00000000
`define FWLIE_LCLK_TMO    8'h10
`endif

//--- fwlie_sync.v
// Three-stage synchroniser with agreement-qualified output and edge
`timescale 1ns/100ps
module fwlie_sync #(
	parameter W = 1
) (
	// Clock and reset
	input  wire         clock,
	input  wire         rst_n,
	// Data
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] level,
	output wire [W-1:0] rise,
	output wire [W-1:0] change
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1    <= {W{1'b0}};
			s2    <= {W{1'b0}};
			s3    <= {W{1'b0}};
			level <= {W{1'b0}};
		end else begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
			// Only agreeing stages count as a change
			level <= (s2 & s3) | (level & (s2 | s3));
		end
	end
	wire [W-1:0] next_level = (s2 & s3) | (level & (s2 | s3));
	assign rise   = next_level & ~level;
	assign change = next_level ^ level;
endmodule // fwlie_sync

//--- fwlie_cycle.v
// Cycle timing event detector on the system clock
`timescale 1ns/100ps
module fwlie_cycle (
	// Clock and reset
	input  wire clock,
	input  wire rst_n,
	// Qualified events
	input  wire cycle_lsb_chg,
	input  wire start_seen,
	input  wire subaction_gap,
	input  wire arb_reset_gap,
	// Event pulses
	output reg  lost
);
	reg armed;
	reg first_gap;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			armed     <= 1'b0;
			first_gap <= 1'b0;
			lost      <= 1'b0;
		end else begin
			lost <= 1'b0;
			if (start_seen) begin
				armed <= 1'b0;
				first_gap <= 1'b0;
			end
			if (cycle_lsb_chg) begin
				if (armed)
					lost <= 1'b1;
				armed     <= 1'b1;
				first_gap <= 1'b1;
			end else if (armed && !start_seen &&
				((subaction_gap && first_gap) || arb_reset_gap)) begin
				lost      <= 1'b1;
				armed     <= 1'b0;
				first_gap <= 1'b0;
			end else if (subaction_gap) begin
				first_gap <= 1'b0;
			end
		end
	end
endmodule // fwlie_cycle

//--- fwlie_top.v
// Link event register block with Wishbone slave
`timescale 1ns/100ps
`include "fwlie_regs.vh"
module fwlie_top #(
	parameter IRX_N = 4,
	parameter ITX_N = 4
) (
	// Clock and reset
	input  wire             clock,
	input  wire             rst_n,
	// Wishbone slave
	input  wire             wb_cyc_i,
	input  wire             wb_stb_i,
	input  wire             wb_we_i,
	input  wire [7:0]       wb_adr_i,
	input  wire [3:0]       wb_sel_i,
	input  wire [31:0]      wb_dat_i,
	output reg  [31:0]      wb_dat_o,
	output reg              wb_ack_o,
	// Link clock and PHY-side levels
	input  wire             link_clock,
	input  wire             cycle_seconds_bit7,
	input  wire             cycle_count_lsb,
	input  wire             cycle_start_seen,
	input  wire             subaction_gap,
	input  wire             arb_reset_gap,
	input  wire             phy_status_irq,
	input  wire             phy_bus_reset,
	input  wire             self_id_stream_done,
	// Core events, same clock
	input  wire             reg_access_failed,
	input  wire             lock_response_no_ack,
	input  wire             posted_write_bus_error,
	input  wire             response_packet_stored,
	input  wire             request_packet_stored,
	input  wire             async_receive_response_context,
	input  wire             async_receive_request_context,
	input  wire             async_transmit_response_context,
	input  wire             async_transmit_request_context,
	// Isochronous per-context event and mask
	input  wire [IRX_N-1:0] irx_event,
	input  wire [IRX_N-1:0] irx_mask,
	input  wire [ITX_N-1:0] itx_event,
	input  wire [ITX_N-1:0] itx_mask,
	// Interrupt and status
	output reg              irq,
	output reg              link_clock_absent
);
	localparam NS = 10;
	wire [NS-1:0] s_lvl;
	wire [NS-1:0] s_rise;
	wire [NS-1:0] s_chg;
	fwlie_sync #(
		.W (NS)
	) u_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in ({link_clock, cycle_seconds_bit7, cycle_count_lsb,
			cycle_start_seen, subaction_gap, arb_reset_gap,
			phy_status_irq, phy_bus_reset, self_id_stream_done,
			1'b0}),
		.level    (s_lvl),
		.rise     (s_rise),
		.change   (s_chg)
	);
	wire lost_pulse;
	fwlie_cycle u_cycle (
		.clock         (clock),
		.rst_n         (rst_n),
		.cycle_lsb_chg (s_chg[7]),
		.start_seen    (s_rise[6]),
		.subaction_gap (s_rise[5]),
		.arb_reset_gap (s_rise[4]),
		.lost          (lost_pulse)
	);
	// Link clock watchdog on its edges
	reg [7:0] lclk_cnt;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lclk_cnt          <= 8'h00;
			link_clock_absent <= 1'b1;
		end else if (s_chg[9]) begin
			lclk_cnt          <= 8'h00;
			link_clock_absent <= 1'b0;
		end else if (lclk_cnt == `FWLIE_LCLK_TMO) begin
			link_clock_absent <= 1'b1;
		end else begin
			lclk_cnt <= lclk_cnt + 8'h01;
		end
	end
	// Bus handshake
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr  = req & wb_we_i & (&wb_sel_i);
	wire rd  = req & ~wb_we_i;
	wire rd_raw = rd & (wb_adr_i == `FWLIE_RAW);
	// Raw read needs the link clock; failure is flagged at once
	wire raf_ev = reg_access_failed | (rd_raw & link_clock_absent);
	// Hardware set vector
	reg  [31:0] hw_set;
	always @* begin
		hw_set = 32'h00000000;
		hw_set[`FWLIE_LOST_BIT] = lost_pulse;
		hw_set[`FWLIE_S64_BIT]  = s_chg[8];
		hw_set[`FWLIE_CYC_BIT]  = s_chg[7];
		hw_set[`FWLIE_PHY_BIT]  = s_rise[3];
		hw_set[`FWLIE_RAF_BIT]  = raf_ev;
		hw_set[`FWLIE_BR_BIT]   = s_rise[2];
		hw_set[`FWLIE_ID_BIT]   = s_rise[1];
		hw_set[`FWLIE_ID2_BIT]  = s_rise[1];
		hw_set[`FWLIE_LOCK_BIT] = lock_response_no_ack;
		hw_set[`FWLIE_PW_BIT]   = posted_write_bus_error;
		hw_set[`FWLIE_RSPPKT_BIT] = response_packet_stored;
		hw_set[`FWLIE_REQPKT_BIT] = request_packet_stored;
		hw_set[`FWLIE_RXRSP_BIT]  = async_receive_response_context;
		hw_set[`FWLIE_RXREQ_BIT]  = async_receive_request_context;
		hw_set[`FWLIE_TXRSP_BIT]  = async_transmit_response_context;
		hw_set[`FWLIE_TXREQ_BIT]  = async_transmit_request_context;
	end
	reg  [31:0] evt;
	reg  [31:0] msk;
	wire [31:0] sw_set  = (wr && wb_adr_i == `FWLIE_EVT_SET) ?
		wb_dat_i : 32'h00000000;
	wire [31:0] sw_clr  = (wr && wb_adr_i == `FWLIE_EVT_CLR) ?
		wb_dat_i : 32'h00000000;
	// Bus reset entry wipes self-ID done, unless it is set this cycle
	wire [31:0] br_clr  = (hw_set[`FWLIE_BR_BIT] && !hw_set[`FWLIE_ID_BIT]) ?
		(32'h00000001 << `FWLIE_ID_BIT) : 32'h00000000;
	// Set by edge or port, cleared by clear port or, for self-ID done, by bus reset entry
	wire [31:0] next_evt = (((evt | sw_set) & ~sw_clr & ~br_clr) | hw_set) &
		`FWLIE_LATCH_MASK;
	wire [31:0] next_msk =
		(wr && wb_adr_i == `FWLIE_MSK_SET) ? (msk | wb_dat_i) &
			`FWLIE_MASK_MASK :
		(wr && wb_adr_i == `FWLIE_MSK_CLR) ? msk & ~wb_dat_i : msk;
	wire irx_sum = |(irx_event & irx_mask);
	wire itx_sum = |(itx_event & itx_mask);
	// Reserved bits stay zero via the latch mask
	wire [31:0] evt_view = evt |
		({31'h00000000, irx_sum} << `FWLIE_IRX_BIT) |
		({31'h00000000, itx_sum} << `FWLIE_ITX_BIT);
	// Event read is event AND mask
	wire [31:0] evt_read = evt_view & msk & ~(32'h00000001 << `FWLIE_GATE_BIT);
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			evt      <= `FWLIE_EVT_RESET;
			msk      <= `FWLIE_MSK_RESET;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			irq      <= 1'b0;
		end else begin
			evt      <= next_evt;
			msk      <= next_msk;
			wb_ack_o <= req;
			irq      <= msk[`FWLIE_GATE_BIT] & (|evt_read);
			if (rd) begin
				case (wb_adr_i)
				`FWLIE_EVT_SET,
				`FWLIE_EVT_CLR: wb_dat_o <= evt_read;
				`FWLIE_MSK_SET,
				`FWLIE_MSK_CLR: wb_dat_o <= msk;
				`FWLIE_RAW:     wb_dat_o <= link_clock_absent ?
					32'h00000000 : evt_view;
				default:        wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // fwlie_top

//--- fwlie_phy_model.sv
// Behavioural PHY side: free link clock that can be stopped
`timescale 1ns/100ps
module fwlie_phy_model (
	// Control
	input  wire run,
	// Link clock
	output reg  link_clock
);
	initial begin
		link_clock = 1'b0;
		forever #160 link_clock = run ? ~link_clock : 1'b0;
	end
endmodule // fwlie_phy_model

//--- fwlie_top_assertions.sv
// Port checker for the event block
`timescale 1ns/100ps
module fwlie_chk #(
	parameter IRX_N = 4,
	parameter ITX_N = 4
) (
	// Clock and reset
	input  wire             clock,
	input  wire             rst_n,
	// Bus
	input  wire             wb_cyc_i,
	input  wire             wb_stb_i,
	input  wire             wb_we_i,
	input  wire [7:0]       wb_adr_i,
	input  wire [31:0]      wb_dat_o,
	input  wire             wb_ack_o,
	// Status and contexts
	input  wire             link_clock_absent,
	input  wire [IRX_N-1:0] irx_event,
	input  wire [IRX_N-1:0] irx_mask,
	input  wire [ITX_N-1:0] itx_event,
	input  wire [ITX_N-1:0] itx_mask
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire rd = wb_ack_o & ~wb_we_i;
	wire raw = rd & (wb_adr_i == 8'h90);
	property p_ack_once;
		wb_cyc_i & wb_stb_i & ~wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack late");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
	property p_rsvd;
		rd && wb_adr_i >= 8'h80 && wb_adr_i <= 8'h90 |-> wb_dat_o[14:10] == 5'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved set");
	property p_gate_rd;
		rd && (wb_adr_i == 8'h80 || wb_adr_i == 8'h84) |-> !wb_dat_o[31];
	endproperty
	a_gate_rd: assert property (p_gate_rd) else $error("bit31 read");
	property p_absent;
		raw && $past(link_clock_absent) |-> wb_dat_o == 32'h0;
	endproperty
	a_absent: assert property (p_absent) else $error("failed read data");
	property p_irx;
		raw && !$past(link_clock_absent) && $stable(irx_event) && $stable(irx_mask)
			|-> wb_dat_o[7] == |($past(irx_event) & $past(irx_mask));
	endproperty
	a_irx: assert property (p_irx) else $error("rx summary");
	property p_itx;
		raw && !$past(link_clock_absent) && $stable(itx_event) && $stable(itx_mask)
			|-> wb_dat_o[6] == |($past(itx_event) & $past(itx_mask));
	endproperty
	a_itx: assert property (p_itx) else $error("tx summary");
endmodule // fwlie_chk
bind fwlie_top fwlie_chk #(.IRX_N(IRX_N), .ITX_N(ITX_N)) u_chk (
	.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .link_clock_absent(link_clock_absent),
	.irx_event(irx_event), .irx_mask(irx_mask), .itx_event(itx_event),
	.itx_mask(itx_mask));

//--- testbench.sv
// Register-level bench for the event block
`timescale 1ns/100ps
`include "fwlie_regs.vh"
module testbench;
	logic        clock, rst_n, cyc, stb, we, run, s7, lsb, phy, br, sid;
	logic        cs, gap, arb;
	logic [7:0]  adr;
	logic [3:0]  sel, ie, im, te, tm;
	logic [31:0] dat, q;
	logic [8:0]  p;
	wire  [31:0] rdata;
	wire         ack, irq, lca, lclk;
	int          err_count, check_count, n_clk, i;
	int          bits [9] = '{18, 9, 8, 5, 4, 3, 2, 1, 0};
	fwlie_phy_model phy_m (.run(run), .link_clock(lclk));
	fwlie_top dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdata), .wb_ack_o(ack), .link_clock(lclk),
		.cycle_seconds_bit7(s7), .cycle_count_lsb(lsb),
		.cycle_start_seen(cs), .subaction_gap(gap), .arb_reset_gap(arb),
		.phy_status_irq(phy), .phy_bus_reset(br), .self_id_stream_done(sid),
		.reg_access_failed(p[0]), .lock_response_no_ack(p[1]),
		.posted_write_bus_error(p[2]), .response_packet_stored(p[3]),
		.request_packet_stored(p[4]), .async_receive_response_context(p[5]),
		.async_receive_request_context(p[6]),
		.async_transmit_response_context(p[7]),
		.async_transmit_request_context(p[8]), .irx_event(ie), .irx_mask(im),
		.itx_event(te), .itx_mask(tm), .irq(irq), .link_clock_absent(lca));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task end_sim;
		$display("Errors %0d, checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Held until ack is sampled high at a rising edge, then released
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		{cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
		do @(posedge clock); while (ack !== 1'b1);
		q = rdata;
		{cyc, stb} <= 2'b00;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// Settle, read raw, then clear every latched event
	task ev(input logic [31:0] e);
		repeat (12) @(posedge clock);
		rd(8'h90, e);
		wb(1'b1, 8'h84, 32'hffffffff);
	endtask
	always @(posedge clock) begin
		n_clk++;
		if (n_clk == 20000) begin
			err_count++;
			end_sim;
		end
	end
	initial begin
		{cyc, stb, we, adr, dat, run, s7, lsb, phy, br, sid} = '0;
		{p, ie, im, te, tm, q} = '0;
		{cs, gap, arb} = '0;
		sel = 4'hf;
		rst_n = 1'b0;
		{err_count, check_count, n_clk} = '0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		chk(lca, 1);
		rd(8'h90, 32'h0);
		run <= 1'b1;
		ev(32'h00040000);
		rd(8'h88, `FWLIE_MSK_RESET);
		wb(1'b1, 8'h88, 32'hffffffff);
		rd(8'h8c, `FWLIE_MASK_MASK);
		sel <= 4'h1;
		wb(1'b1, 8'h80, 32'hffffffff);
		sel <= 4'hf;
		rd(8'h80, 32'h0);
		wb(1'b1, 8'h80, 32'hffffffff);
		rd(8'h80, `FWLIE_LATCH_MASK);
		chk(irq, 1);
		wb(1'b1, 8'h84, 32'hffffffff);
		rd(8'h84, 32'h0);
		chk(irq, 0);
		rd(8'h40, 32'h0);
		for (i = 0; i < 9; i++) begin
			@(posedge clock) p <= 9'h1 << i;
			@(posedge clock) p <= 9'h0;
			ev(32'h1 << bits[i]);
		end
		// Source pulse meets clear write at the same edge
		fork
			wb(1'b1, 8'h84, 32'h00000200);
			begin
				@(posedge clock) p <= 9'h002;
				@(posedge clock) p <= 9'h000;
			end
		join
		ev(32'h00000200);
		wb(1'b1, 8'h8c, 32'h80000000);
		wb(1'b1, 8'h80, 32'h00000200);
		repeat (3) @(posedge clock);
		chk(irq, 0);
		wb(1'b1, 8'h88, 32'h80000000);
		repeat (2) @(posedge clock);
		chk(irq, 1);
		wb(1'b1, 8'h84, 32'hffffffff);
		phy <= 1'b1;
		ev(32'h00080000);
		s7 <= 1'b1;
		ev(32'h00200000);
		lsb <= 1'b1;
		ev(32'h00100000);
		lsb <= 1'b0;
		ev(32'h00500000);
		cs <= 1'b1;
		ev(32'h00000000);
		lsb <= 1'b1;
		ev(32'h00100000);
		gap <= 1'b1;
		ev(32'h00400000);
		lsb <= 1'b0;
		ev(32'h00100000);
		arb <= 1'b1;
		ev(32'h00400000);
		sid <= 1'b1;
		repeat (12) @(posedge clock);
		rd(8'h90, 32'h00018000);
		br <= 1'b1;
		ev(32'h00028000);
		{ie, im, te, tm} <= {4'h3, 4'h2, 4'h4, 4'h1};
		ev(32'h00000080);
		tm <= 4'h4;
		ev(32'h000000c0);
		end_sim;
	end
endmodule // testbench
